// *** verilog/dac_port_pkg.sv ***
// Shared constants and types for the DAC serial write port
package dac_port_pkg;

   // Frame layout, most significant bit first on the wire
   localparam int FRAME_BITS = 24;
   localparam int IGNORED_BITS = 6;
   localparam int MODE_BITS = 2;
   localparam int CODE_BITS = 16;
   localparam int POWER_MODE_HI_POS = 17;
   localparam int POWER_MODE_LO_POS = 16;
   localparam int CODE_MSB_POS = 15;
   localparam int CODE_LSB_POS = 0;

   // Edge counter: width and the value after the final bit
   localparam int EDGE_W = 5;
   localparam logic [EDGE_W-1:0] EDGE_ZERO = 5'h00;
   localparam logic [EDGE_W-1:0] EDGE_STEP = 5'h01;
   localparam logic [EDGE_W-1:0] EDGE_LAST = 5'h18;
   localparam logic [EDGE_W-1:0] EDGE_FINAL_BIT = 5'h17;

   // Converter resolutions and the code masks they imply
   localparam int RES_12 = 12;
   localparam int RES_16 = 16;
   localparam logic [CODE_BITS-1:0] CODE_MASK_12 = 16'hFFF0;
   localparam logic [CODE_BITS-1:0] CODE_MASK_16 = 16'hFFFF;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 16'h0000;

   // Power-up settling after leaving power-down
   localparam int CLK_PERIOD_PS = 5000;
   localparam int WAKE_TIME_NS = 2500;
   localparam int WAKE_CYCLES =
      (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

   // Buffer between the frame receiver and the converter
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_STAGES_W = 2;

   // Operating mode carried in the two control bits
   typedef enum logic [MODE_BITS-1:0] {
      MODE_NORMAL = 2'h0,
      MODE_GND_1K = 2'h1,
      MODE_GND_100K = 2'h2,
      MODE_HIGH_Z = 2'h3
   } power_mode_t;

   // One executed frame: mode plus left-aligned code
   typedef struct packed {
      power_mode_t mode;
      logic [CODE_BITS-1:0] code;
   } dac_word_t;

   localparam int WORD_W = $bits(dac_word_t);

   // Output stage switch settings
   typedef struct packed {
      logic driven;
      logic shunt1k;
      logic shunt100k;
      logic highZ;
   } out_stage_t;

endpackage : dac_port_pkg

// *** verilog/level_sync.sv ***
// Two-flop synchroniser for a group of slow levels
`timescale 1ns/1ps
`default_nettype none
module level_sync
   import dac_port_pkg::*;
#(
   parameter int WIDTH = SYNC_STAGES_W
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t state_q;
   sync_state_t state_d;

   // First stage feeds only the second stage
   always_comb
   begin
      state_d.meta = asyncIn;
      state_d.stable = state_q.meta;
   end

   // Both stages clear on reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign syncOut = state_q.stable;

endmodule : level_sync
`default_nettype wire

// *** verilog/word_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [$clog2(DEPTH):0] level
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
   } fifo_state_t;

   fifo_state_t state_q;
   fifo_state_t state_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign level = state_q.wrPtr - state_q.rdPtr;
   assign inReady = (level != (AW+1)'(DEPTH));
   assign outValid = (level != '0);
   assign outData = mem[state_q.rdPtr[AW-1:0]];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Pointer advance
   always_comb
   begin
      state_d = state_q;
      if (push)
         state_d.wrPtr = state_q.wrPtr + 1'b1;
      if (pop)
         state_d.rdPtr = state_q.rdPtr + 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   // Storage needs no reset; empty slots are never read out
   always_ff @(posedge clk)
   begin
      if (push)
         mem[state_q.wrPtr[AW-1:0]] <= inData;
   end

endmodule : word_fifo
`default_nettype wire

// *** verilog/dac_serial_write_port.sv ***
// Serial write port of a voltage-output DAC with frame buffer
//
// What the document requires of the port and its host
// RULE1: 24-bit frame: six ignored, two mode, sixteen code
// RULE2: Two control bits pick normal or power-down
// RULE3: Modes 00 normal, 01 1k, 10 100k, 11 open
// RULE4: Left-aligned code loads on 24th falling edge; here dacCode loads later, when the buffer pops it
// RULE5: 12-bit variant uses upper code bits only
// RULE6: Frame select falling starts a new frame
// RULE7: Data sampled on every falling clock edge; here only the first 24 falling edges of a frame are sampled
// RULE8: Host sends most significant bit first
// RULE9: Host keeps shift clock at 30 MHz or less
// RULE10: 24th falling edge executes the frame; here captured then, applied later from the buffer, dropped on overflow
// RULE11: Frame select may stay low or rise after
// RULE12: Frame select high 33 ns between frames
// RULE13: Early frame select rise discards the frame
// RULE14: Aborted frame changes neither code nor mode
// RULE15: Byte hosts hold select low over three bytes
// RULE16: Host uses clock polarity 0, phase 1
// RULE17: Code clears to zero at power up
// RULE18: Power-down keeps the stored code
// RULE19: Edge counter clears while frame select high
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port
   import dac_port_pkg::*;
#(
   parameter int RESOLUTION = RES_16,
   parameter int BUF_DEPTH = FIFO_DEPTH
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic frameSelN,
   input wire logic sdi,
   input wire logic dacReady,
   output logic [CODE_BITS-1:0] dacCode,
   output power_mode_t powerMode,
   output logic dacLoad,
   output logic outputDriven,
   output logic shunt1k,
   output logic shunt100k,
   output logic outputHighZ,
   output logic outputSettled,
   output logic frameBusy,
   output logic fifoInReady,
   output logic frameOverflow,
   output logic [CODE_BITS-1:0] validFrames,
   output logic [$clog2(BUF_DEPTH):0] fifoLevel
);

   // Code bits that a given resolution really keeps
   localparam logic [CODE_BITS-1:0] CODE_MASK =
      (RESOLUTION == RES_12) ? CODE_MASK_12 : CODE_MASK_16;
   localparam logic [WAKE_W-1:0] WAKE_COUNT = WAKE_W'(WAKE_CYCLES);
   localparam logic [WAKE_W-1:0] WAKE_ONE = WAKE_W'(1);

   // Decode of the mode bits into output stage switches
   function automatic out_stage_t stageOf(input power_mode_t m);
      out_stage_t s;
      s = '0;
      case (m)
         MODE_NORMAL: s.driven = 1'b1;
         MODE_GND_1K: s.shunt1k = 1'b1;
         MODE_GND_100K: s.shunt100k = 1'b1;
         MODE_HIGH_Z: s.highZ = 1'b1;
         default: s.highZ = 1'b1;
      endcase
      return s;
   endfunction : stageOf

   // Split a received frame into mode and code fields
   function automatic dac_word_t wordOf(input logic [FRAME_BITS-1:0] f);
      dac_word_t w;
      w.mode = power_mode_t'({f[POWER_MODE_HI_POS],
                              f[POWER_MODE_LO_POS]}); // RULE2
      w.code = f[CODE_MSB_POS:CODE_LSB_POS]; // RULE4
      return w;
   endfunction : wordOf

   // ------------------------------------------------------------
   // Link side, clocked by the falling edge of the shift clock
   // ------------------------------------------------------------

   typedef struct packed {
      logic [EDGE_W-1:0] edges;
      logic [FRAME_BITS-1:0] shift;
   } link_frame_t;

   typedef struct packed {
      dac_word_t word;
      logic doneToggle;
   } link_result_t;

   link_frame_t frame_q;
   link_frame_t frame_d;
   link_result_t result_q;
   link_result_t result_d;
   logic frameRst_n;
   logic [FRAME_BITS-1:0] frameWord;

   // Select high holds the frame logic in reset; this both clears
   // the counter between frames and discards a partial frame
   // without needing shift clock edges that may never come
   assign frameRst_n = arst_n & ~frameSelN; // RULE13 RULE19 RULE6

   // Word as it stands once this edge's bit is shifted in
   assign frameWord = {frame_q.shift[FRAME_BITS-2:0], sdi}; // RULE8

   // Shift one bit per edge; stop counting after the last bit
   always_comb
   begin
      frame_d = frame_q;
      if (frame_q.edges != EDGE_LAST) // RULE11
      begin
         frame_d.shift = frameWord; // RULE7 RULE1
         frame_d.edges = frame_q.edges + EDGE_STEP; // RULE19
      end
   end

   // Final bit executes the frame: capture and flag it
   always_comb
   begin
      result_d = result_q;
      if (frame_q.edges == EDGE_FINAL_BIT) // RULE10 RULE4 RULE14
      begin
         result_d.word = wordOf(frameWord);
         result_d.doneToggle = ~result_q.doneToggle;
      end
   end

   always_ff @(negedge sclk or negedge frameRst_n)
   begin
      if (!frameRst_n)
         frame_q <= '0; // RULE13
      else
         frame_q <= frame_d;
   end

   // Survives select rising so a finished frame is not lost
   always_ff @(negedge sclk or negedge arst_n)
   begin
      if (!arst_n)
         result_q <= '0;
      else
         result_q <= result_d;
   end

   // ------------------------------------------------------------
   // Crossing into the system clock domain
   // ------------------------------------------------------------

   logic [SYNC_STAGES_W-1:0] syncIn;
   logic [SYNC_STAGES_W-1:0] syncOut;
   logic toggleSync;
   logic selActive;

   // Select is inverted first so a cleared synchroniser reads idle
   assign syncIn = {result_q.doneToggle, ~frameSelN};
   assign toggleSync = syncOut[1];
   assign selActive = syncOut[0];

   level_sync #(
      .WIDTH(SYNC_STAGES_W)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .asyncIn(syncIn),
      .syncOut(syncOut)
   );

   // ------------------------------------------------------------
   // System side: buffer and apply executed frames
   // ------------------------------------------------------------

   typedef struct packed {
      logic togglePrev;
      logic pushValid;
      dac_word_t pushWord;
      logic [CODE_BITS-1:0] code;
      power_mode_t mode;
      logic loadPulse;
      logic overflow;
      logic [CODE_BITS-1:0] frames;
      logic [WAKE_W-1:0] wakeCount;
      logic settled;
      logic busy;
   } core_state_t;

   localparam core_state_t CORE_RESET = '{
      togglePrev: 1'b0,
      pushValid: 1'b0,
      pushWord: '0,
      code: CODE_RESET,
      mode: MODE_NORMAL,
      loadPulse: 1'b0,
      overflow: 1'b0,
      frames: '0,
      wakeCount: '0,
      settled: 1'b1,
      busy: 1'b0
   };

   core_state_t core_q;
   core_state_t core_d;
   logic newFrame;
   logic fifoOutValid;
   logic pop;
   logic [WORD_W-1:0] fifoOutData;
   dac_word_t popWord;
   out_stage_t stage;

   // A toggle edge means one complete frame. The held word is
   // stable for a full frame time, far longer than the crossing
   assign newFrame = toggleSync ^ core_q.togglePrev;
   assign pop = fifoOutValid && dacReady;
   assign popWord = dac_word_t'(fifoOutData);

   word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .inValid(core_q.pushValid),
      .inReady(fifoInReady),
      .inData(core_q.pushWord),
      .outValid(fifoOutValid),
      .outReady(dacReady),
      .outData(fifoOutData),
      .level(fifoLevel)
   );

   // Next state of the converter side
   always_comb
   begin
      core_d = core_q;
      core_d.loadPulse = 1'b0;
      core_d.togglePrev = toggleSync;
      core_d.busy = selActive;
      // Pending word leaves once the buffer takes it
      if (core_q.pushValid && fifoInReady)
         core_d.pushValid = 1'b0;
      // Queue a fresh frame; drop it if the slot is still held
      if (newFrame)
      begin
         if (core_d.pushValid)
            core_d.overflow = 1'b1;
         else
         begin
            core_d.pushValid = 1'b1;
            core_d.pushWord = result_q.word;
            core_d.frames = core_q.frames + 1'b1;
         end
      end
      // Settling countdown after leaving power-down
      if (core_q.wakeCount != '0)
      begin
         core_d.wakeCount = core_q.wakeCount - WAKE_ONE;
         if (core_q.wakeCount == WAKE_ONE)
            core_d.settled = 1'b1;
      end
      // Apply the oldest buffered frame
      if (pop)
      begin
         core_d.mode = popWord.mode; // RULE2 RULE3
         core_d.loadPulse = 1'b1;
         if (popWord.mode == MODE_NORMAL)
         begin
            core_d.code = popWord.code & CODE_MASK; // RULE4 RULE5
            if (core_q.mode != MODE_NORMAL)
            begin
               core_d.wakeCount = WAKE_COUNT;
               core_d.settled = 1'b0;
            end
         end
         else
         begin
            // Code register untouched while powered down
            core_d.code = core_q.code; // RULE18
            core_d.wakeCount = '0;
            core_d.settled = 1'b0;
         end
      end
   end

   // Power-up state: zero code, normal mode
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         core_q <= CORE_RESET; // RULE17
      else
         core_q <= core_d;
   end

   // Outputs, all from registers
   assign stage = stageOf(core_q.mode); // RULE3
   assign dacCode = core_q.code;
   assign powerMode = core_q.mode;
   assign dacLoad = core_q.loadPulse;
   assign outputDriven = stage.driven;
   assign shunt1k = stage.shunt1k;
   assign shunt100k = stage.shunt100k;
   assign outputHighZ = stage.highZ;
   assign outputSettled = core_q.settled;
   assign frameBusy = core_q.busy;
   assign frameOverflow = core_q.overflow;
   assign validFrames = core_q.frames;

endmodule : dac_serial_write_port
`default_nettype wire

// *** testbench/dac_host_model.sv ***
// Host model: drives frame select, shift clock and serial data
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
   output var logic sclk,
   output var logic frameSelN,
   output var logic sdi
);
   // Idle link: select high, clock stopped low
   initial
   begin
      sclk = 1'b0;
      frameSelN = 1'b1;
      sdi = 1'b0;
   end
   // Sends n bits of w in bytes, then e extra clocks
   task automatic send(input logic [23:0] w, input int n, input int e);
      frameSelN = 1'b0;
      #20;
      for (int i = 0; i < n + e; i++)
      begin
         sclk = 1'b1;
         sdi = (i < 24) ? w[23-i] : ~sdi;
         #62.5 sclk = 1'b0;
         #62.5;
         if (i % 8 == 7) #100;
      end
      sdi = ~sdi;
      #10 frameSelN = 1'b1;
      #40;
   endtask : send
endmodule : dac_host_model
`default_nettype wire

// *** testbench/dac_serial_write_port_properties.sv ***
// Checker for the DAC serial write port outputs
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_properties
   import dac_port_pkg::*;
#(
   parameter int BUF_DEPTH = FIFO_DEPTH
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic frameSelN,
   input wire logic dacReady,
   input wire logic [CODE_BITS-1:0] dacCode,
   input wire power_mode_t powerMode,
   input wire logic dacLoad,
   input wire logic outputDriven,
   input wire logic shunt1k,
   input wire logic shunt100k,
   input wire logic outputHighZ,
   input wire logic outputSettled,
   input wire logic frameBusy,
   input wire logic [CODE_BITS-1:0] validFrames,
   input wire logic [$clog2(BUF_DEPTH):0] fifoLevel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Select level held long enough to pass the synchroniser
   sequence s_low; !frameSelN [*6]; endsequence
   sequence s_high; frameSelN [*8]; endsequence
   property p_busy_on; s_low |-> frameBusy; endproperty
   property p_busy_off; s_high |-> !frameBusy; endproperty
   property p_onehot;
      {outputDriven, shunt1k, shunt100k, outputHighZ} == 4'h8 >> powerMode;
   endproperty
   property p_code; $changed(dacCode) |-> dacLoad; endproperty
   property p_mode; $changed(powerMode) |-> dacLoad; endproperty
   property p_keep;
      dacLoad && powerMode != MODE_NORMAL |-> $stable(dacCode);
   endproperty
   property p_cause;
      dacLoad |-> $past(dacReady) && $past(fifoLevel) != 0;
   endproperty
   property p_count;
      $changed(validFrames) |-> validFrames == $past(validFrames) + 16'h0001;
   endproperty
   property p_wake; powerMode != MODE_NORMAL |=> !outputSettled; endproperty
   a_busy_on: assert property (p_busy_on) else $error("busy");
   a_busy_off: assert property (p_busy_off) else $error("idle");
   a_onehot: assert property (p_onehot) else $error("stage");
   a_code: assert property (p_code) else $error("code");
   a_mode: assert property (p_mode) else $error("mode");
   a_keep: assert property (p_keep) else $error("keep");
   a_cause: assert property (p_cause) else $error("load");
   a_count: assert property (p_count) else $error("count");
   a_wake: assert property (p_wake) else $error("wake");
endmodule : dac_serial_write_port_properties
bind dac_serial_write_port dac_serial_write_port_properties
   #(.BUF_DEPTH(BUF_DEPTH)) u_props (.clk(clk), .arst_n(arst_n),
   .frameSelN(frameSelN), .dacReady(dacReady), .dacCode(dacCode),
   .powerMode(powerMode), .dacLoad(dacLoad), .outputDriven(outputDriven),
   .shunt1k(shunt1k), .shunt100k(shunt100k), .outputHighZ(outputHighZ),
   .outputSettled(outputSettled), .frameBusy(frameBusy),
   .validFrames(validFrames), .fifoLevel(fifoLevel));
`default_nettype wire

// *** testbench/dac_serial_write_port_test.sv ***
// Self-checking bench for the DAC serial write port
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_test;
   import dac_port_pkg::*;
   logic clk, arst_n, sclk, frameSelN, sdi, dacReady;
   logic dacLoad, outputDriven, shunt1k, shunt100k, outputHighZ;
   logic outputSettled, frameBusy, fifoInReady, frameOverflow;
   logic [CODE_BITS-1:0] dacCode, validFrames, expCode, expCount, lastCode;
   logic [4:0] fifoLevel;
   power_mode_t powerMode, expMode;
   logic [31:0] seed;
   int n_fail, total_checks, nLoads, n0;

   dac_serial_write_port u_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk),
      .frameSelN(frameSelN), .sdi(sdi), .dacReady(dacReady),
      .dacCode(dacCode), .powerMode(powerMode), .dacLoad(dacLoad),
      .outputDriven(outputDriven), .shunt1k(shunt1k),
      .shunt100k(shunt100k), .outputHighZ(outputHighZ),
      .outputSettled(outputSettled), .frameBusy(frameBusy),
      .fifoInReady(fifoInReady), .frameOverflow(frameOverflow),
      .validFrames(validFrames), .fifoLevel(fifoLevel));
   dac_host_model u_host (.sclk(sclk), .frameSelN(frameSelN), .sdi(sdi));

   // System clock and count of applied words
   always #2.5 clk = ~clk;
   always @(posedge clk)
      if (dacLoad === 1'b1) nLoads <= nLoads + 1;

   // Pseudo-random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Power-down frames keep the stored code
   function automatic logic [15:0] nextCode(input logic [23:0] w,
      input logic [15:0] old);
      return (w[17:16] == 2'h0) ? w[15:0] : old;
   endfunction : nextCode

   // Compare helpers
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s %h %h", $time, what, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp, input string w);
      chk_val({15'h0000, got}, {15'h0000, exp}, w);
   endtask : chk_bit

   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   // One frame of n bits, then the expected outputs
   task automatic frame(input logic [23:0] w, input int n, input int e);
      int k;
      n0 = nLoads;
      u_host.send(w, n, e);
      k = 0;
      while (nLoads == n0 && k < 60)
      begin
         @(negedge clk);
         k++;
      end
      chk_bit(k < 60, n >= 24, "load");
      if (n >= 24)
      begin
         expCode = nextCode(w, expCode);
         expMode = power_mode_t'(w[17:16]);
         expCount++;
      end
      chk_val(dacCode, expCode, "code");
      chk_val({14'h0000, powerMode}, {14'h0000, expMode}, "mode");
      chk_val(validFrames, expCount, "count");
      if (k == 60 && n >= 24) stop_test();
   endtask : frame

   // Main sequence
   initial
   begin
      clk = 1'b0;
      arst_n = 1'b0;
      dacReady = 1'b1;
      n_fail = 0;
      total_checks = 0;
      nLoads = 0;
      seed = 32'h000115C5;
      expCode = CODE_RESET;
      expMode = MODE_NORMAL;
      expCount = 16'h0000;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk_val(dacCode, CODE_RESET, "reset");
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         frame({seed[23:18], 2'h0, seed[15:0]}, 24, (i % 2) * 3);
      end
      for (int m = 1; m < 4; m++)
         frame({6'h3F, m[1:0], ~expCode}, 24, 0);
      chk_bit(outputSettled, 1'b0, "asleep");
      frame(24'h00FFFF, 24, 0);
      frame(24'h001234, 23, 0);
      chk_bit(outputSettled, 1'b1, "awake");
      frame(24'h03ABCD, 1, 0);
      frame(24'h000000, 24, 0);
      // Converter stalled: fill the buffer and the held slot, then one more
      @(negedge clk);
      dacReady = 1'b0;
      for (int i = 0; i < 18; i++)
      begin
         seed = lfsr(seed);
         u_host.send({8'h00, seed[15:0]}, 24, 0);
         if (i == 16) lastCode = seed[15:0];
      end
      repeat (10) @(negedge clk);
      chk_val({11'h000, fifoLevel}, 16'h0010, "level");
      chk_bit(fifoInReady, 1'b0, "ready");
      chk_bit(frameOverflow, 1'b1, "overflow");
      chk_val(validFrames, expCount + 16'h0011, "frames");
      // Drain with a randomly stalling converter
      n0 = nLoads;
      repeat (80)
      begin
         @(negedge clk);
         seed = lfsr(seed);
         dacReady = seed[0];
      end
      dacReady = 1'b1;
      repeat (20) @(negedge clk);
      chk_val(16'(nLoads - n0), 16'h0011, "drained");
      chk_val(dacCode, lastCode, "last");
      chk_val({11'h000, fifoLevel}, 16'h0000, "empty");
      stop_test();
   end

   // Cuts a hung run short
   initial
   begin
      #400000;
      n_fail++;
      stop_test();
   end
endmodule : dac_serial_write_port_test
`default_nettype wire
